//--- inc/vil_defines.svh
// Purpose: constants for the vectored interrupt logic
// Assumes: byte-wide register port, bank number beside the address
// Notes: vector values are program-memory word addresses
`ifndef VIL_DEFINES_SVH
`define VIL_DEFINES_SVH

// ----------------------------------------
// register offsets and banks
// ----------------------------------------
`define ADDR_INT_STATUS 8'h07
`define ADDR_PFLAG_TWO 8'h10
`define ADDR_PEN_TWO 8'h11
`define ADDR_PFLAG_ONE 8'h16
`define ADDR_PEN_ONE 8'h17
`define BANK_ONE 4'h1
`define BANK_FOUR 4'h4

// ----------------------------------------
// field positions in int_status_control
// ----------------------------------------
`define BIT_EXT_ENABLE 0
`define BIT_TZERO_ENABLE 1
`define BIT_CLKPIN_ENABLE 2
`define BIT_GROUP_ENABLE 3

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define RST_INT_STATUS 8'h00
`define RST_PEN 8'h00
`define RST_PFLAG_ONE 8'h02
`define RST_PFLAG_TWO 8'h02
`define RST_GLOBAL_DISABLE 1'b1
`define MASK_IMPL_TWO 8'hEF
`define MASK_SW_FLAG 8'hFC
`define MASK_HW_FLAG 8'h03

// ----------------------------------------
// vectors
// ----------------------------------------
`define VEC_RESET 8'h00
`define VEC_EXT 8'h08
`define VEC_TZERO 8'h10
`define VEC_CLKPIN 8'h18
`define VEC_PERIPH 8'h20
`define NUM_SOURCES 18

`endif

//--- inc/vil_pkg.sv
// Purpose: types for the vectored interrupt logic
// Assumes: nothing beyond the defines header
// Notes: all module state is one packed struct
package vil_pkg;

	// ----------------------------------------
	// vector selection
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_EXT,
		SEL_TZERO,
		SEL_CLKPIN,
		SEL_PERIPH,
		SEL_RESET
	} vec_sel_e;

	// ----------------------------------------
	// state of the controller
	// ----------------------------------------
	typedef struct packed {
		logic gd;
		logic [3:0] en;
		logic extF;
		logic t0F;
		logic ckF;
		logic [7:0] pe1;
		logic [7:0] pe2;
		logic [7:0] pf1;
		logic [7:0] pf2;
		logic [1:0] extSync;
		logic [1:0] ckSync;
		logic extPrev;
		logic ckPrev;
		logic resetPend;
		logic [7:0] rdData;
		logic vecReq;
		logic [7:0] vecAddr;
		logic stackPush;
		logic stackPop;
		vec_sel_e lastSel;
	} vil_state_s;

endpackage

//--- hw/vectored_interrupt_logic.sv
// Purpose: flags, enables and vector steering for eighteen sources
// Assumes: core pulses cycleStart once per instruction cycle
// Notes: core performs the stack push/pop on the strobes given here
//
// Functional notes
// R1 - eighteen sources, each with own flag
// R2 - global disable blocks every response
// R3 - response sets disable, pushes, loads vector
// R4 - four vectors, peripherals share one
// R5 - vectors 08h, 10h, 18h, 20h
// R6 - non-peripheral vectoring clears its flag
// R7 - peripheral vectoring leaves flags untouched
// R8 - software clears peripheral flags before return
// R9 - flags set regardless of enables
// R10 - no evaluation inside two-cycle instructions
// R11 - return pops stack, clears global disable
// R12 - pending flag ORs enabled peripheral flags
// R13 - group enable gates all peripheral requests
// R14 - set during enable clear vectors 00h
// R15 - software disables globally before clearing enables
// R16 - status register 07h, flags high, enables low
// R17 - selected pin edges set pin flags
// R18 - timer-zero overflow sets flag, requests vector
// R19 - enable one at 17h bank 1
// R20 - enable two at 11h bank 4
// R21 - flag one at 16h, serial bits hardware
// R22 - flag two at 10h, bit 4 zero
// R23 - fixed priority ext, timer, pin, peripherals
// R24 - edge select picks rising or falling
// R25 - one vector request per instruction cycle
`timescale 1ns/1ps
`include "vil_defines.svh"

module vectored_interrupt_logic (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [3:0] regBank,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// core sequencer
	input wire logic cycleStart,
	input wire logic instrBusy,
	input wire logic retfieExec,
	input wire logic glintdWr,
	input wire logic glintdWrData,
	output logic globalIrqDisable,
	output logic vecReq,
	output logic [7:0] vecAddr,
	output vil_pkg::vec_sel_e vecSource,
	output logic stackPush,
	output logic stackPop,
	// sources
	input wire logic extIrqPin,
	input wire logic timerClockPin,
	input wire logic extEdgeSelect,
	input wire logic clkEdgeSelect,
	input wire logic timerZeroOvf,
	input wire logic [7:0] evtOne,
	input wire logic [7:0] evtTwo
);
	import vil_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	vil_state_s s;
	vil_state_s next_s;
	logic extEdge;
	logic ckEdge;
	logic wrStat;
	logic wrPe1;
	logic wrPe2;
	logic wrPf1;
	logic wrPf2;
	logic pend;
	logic perSetEvt;
	logic [3:0] reqs;
	logic [3:0] setNow;
	logic [3:0] cleared;
	logic evalNow;
	vec_sel_e sel;

	// ----------------------------------------
	// decode and source conditioning
	// ----------------------------------------
	// pin edges only from the second sync stage onward
	always_comb begin
		if (extEdgeSelect) begin // R24
			extEdge = s.extSync[1] & ~s.extPrev;
		end else begin
			extEdge = ~s.extSync[1] & s.extPrev;
		end
		if (clkEdgeSelect) begin // R17
			ckEdge = s.ckSync[1] & ~s.ckPrev;
		end else begin
			ckEdge = ~s.ckSync[1] & s.ckPrev;
		end
	end

	assign wrStat = regWr && regAddr == `ADDR_INT_STATUS;
	assign wrPe1 = regWr && regBank == `BANK_ONE && regAddr == `ADDR_PEN_ONE; // R19
	assign wrPf1 = regWr && regBank == `BANK_ONE && regAddr == `ADDR_PFLAG_ONE; // R21
	assign wrPe2 = regWr && regBank == `BANK_FOUR && regAddr == `ADDR_PEN_TWO; // R20
	assign wrPf2 = regWr && regBank == `BANK_FOUR && regAddr == `ADDR_PFLAG_TWO; // R22

	// pending ignores the group enable; the group enable gates the request
	assign pend = |((s.pf1 & s.pe1) | (s.pf2 & s.pe2)); // R12
	// only a rising flag counts; held serial levels must not re-arm a restart
	assign perSetEvt = |((evtOne & ~s.pf1 & s.pe1)
		| (evtTwo & ~s.pf2 & s.pe2 & `MASK_IMPL_TWO));

	// R23
	assign reqs[0] = s.extF & s.en[`BIT_EXT_ENABLE];
	assign reqs[1] = s.t0F & s.en[`BIT_TZERO_ENABLE]; // R18
	assign reqs[2] = s.ckF & s.en[`BIT_CLKPIN_ENABLE];
	assign reqs[3] = pend & s.en[`BIT_GROUP_ENABLE]; // R13

	assign setNow = {perSetEvt, ckEdge, timerZeroOvf, extEdge};
	assign cleared = wrStat ? (s.en & ~regWrData[3:0]) : 4'h0;

	// R10 R25
	assign evalNow = cycleStart && !instrBusy && !s.gd; // R2

	// ----------------------------------------
	// winner selection
	// ----------------------------------------
	always_comb begin
		sel = SEL_NONE;
		if (evalNow) begin
			if (s.resetPend) begin // R14
				sel = SEL_RESET;
			end else if (reqs[0]) begin // R23
				sel = SEL_EXT;
			end else if (reqs[1]) begin
				sel = SEL_TZERO;
			end else if (reqs[2]) begin
				sel = SEL_CLKPIN;
			end else if (reqs[3]) begin
				sel = SEL_PERIPH;
			end
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.extSync = {s.extSync[0], extIrqPin};
		next_s.ckSync = {s.ckSync[0], timerClockPin};
		next_s.extPrev = s.extSync[1];
		next_s.ckPrev = s.ckSync[1];
		next_s.vecReq = 1'b0;
		next_s.stackPush = 1'b0;
		next_s.stackPop = 1'b0;

		// status register, bit 7 is read only
		if (wrStat) begin // R16
			next_s.en = regWrData[3:0];
			next_s.ckF = regWrData[6];
			next_s.t0F = regWrData[5];
			next_s.extF = regWrData[4];
		end
		if (wrPe1) begin
			next_s.pe1 = regWrData;
		end
		if (wrPe2) begin
			next_s.pe2 = regWrData & `MASK_IMPL_TWO;
		end
		if (wrPf1) begin
			next_s.pf1 = (regWrData & `MASK_SW_FLAG) | (s.pf1 & `MASK_HW_FLAG);
		end
		if (wrPf2) begin
			next_s.pf2 = (regWrData & `MASK_SW_FLAG & `MASK_IMPL_TWO)
				| (s.pf2 & `MASK_HW_FLAG);
		end

		// global disable from core writes and return; vectoring below also sets it
		if (glintdWr) begin
			next_s.gd = glintdWrData;
		end
		if (retfieExec) begin // R11
			next_s.gd = 1'b0;
			next_s.stackPop = 1'b1;
		end

		// enable cleared as its flag sets: restart vector armed
		if (!s.gd && |(cleared & setNow)) begin // R14
			next_s.resetPend = 1'b1;
		end

		// R3 R4 R5
		case (sel)
			SEL_RESET: begin
				next_s.vecAddr = `VEC_RESET;
				next_s.resetPend = 1'b0;
			end
			SEL_EXT: begin
				next_s.vecAddr = `VEC_EXT;
				next_s.extF = 1'b0; // R6
			end
			SEL_TZERO: begin
				next_s.vecAddr = `VEC_TZERO;
				next_s.t0F = 1'b0; // R6
			end
			SEL_CLKPIN: begin
				next_s.vecAddr = `VEC_CLKPIN;
				next_s.ckF = 1'b0; // R6
			end
			SEL_PERIPH: begin
				// flags stay; software polls and clears them
				next_s.vecAddr = `VEC_PERIPH; // R7
			end
			default: begin
				next_s.vecAddr = s.vecAddr;
			end
		endcase
		if (sel != SEL_NONE) begin
			next_s.vecReq = 1'b1; // R3 R25
			next_s.stackPush = 1'b1;
			next_s.gd = 1'b1;
			next_s.lastSel = sel;
		end

		// hardware sets win over software and auto clears
		if (extEdge) begin // R9 R17
			next_s.extF = 1'b1;
		end
		if (timerZeroOvf) begin // R9 R18
			next_s.t0F = 1'b1;
		end
		if (ckEdge) begin // R9 R17
			next_s.ckF = 1'b1;
		end
		// R1 R9
		next_s.pf1 = (next_s.pf1 & `MASK_SW_FLAG) | (evtOne & `MASK_SW_FLAG)
			| (evtOne & `MASK_HW_FLAG); // R21
		next_s.pf2 = ((next_s.pf2 & `MASK_SW_FLAG) | evtTwo) & `MASK_IMPL_TWO; // R22

		// read data stands one cycle only
		next_s.rdData = 8'h00;
		if (regRd) begin
			if (regAddr == `ADDR_INT_STATUS) begin
				next_s.rdData = {pend, s.ckF, s.t0F, s.extF, s.en};
			end else if (regBank == `BANK_ONE && regAddr == `ADDR_PEN_ONE) begin
				next_s.rdData = s.pe1;
			end else if (regBank == `BANK_ONE && regAddr == `ADDR_PFLAG_ONE) begin
				next_s.rdData = s.pf1;
			end else if (regBank == `BANK_FOUR && regAddr == `ADDR_PEN_TWO) begin
				next_s.rdData = s.pe2;
			end else if (regBank == `BANK_FOUR && regAddr == `ADDR_PFLAG_TWO) begin
				next_s.rdData = s.pf2;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			s.gd <= `RST_GLOBAL_DISABLE;
			s.en <= 4'h0;
			s.extF <= 1'b0;
			s.t0F <= 1'b0;
			s.ckF <= 1'b0;
			s.pe1 <= `RST_PEN;
			s.pe2 <= `RST_PEN;
			s.pf1 <= `RST_PFLAG_ONE;
			s.pf2 <= `RST_PFLAG_TWO;
			s.extSync <= 2'h0;
			s.ckSync <= 2'h0;
			s.extPrev <= 1'b0;
			s.ckPrev <= 1'b0;
			s.resetPend <= 1'b0;
			s.rdData <= 8'h00;
			s.vecReq <= 1'b0;
			s.vecAddr <= `VEC_RESET;
			s.stackPush <= 1'b0;
			s.stackPop <= 1'b0;
			s.lastSel <= SEL_NONE;
		end else begin
			s <= next_s;
		end
	end

	assign regRdData = s.rdData;
	assign globalIrqDisable = s.gd;
	assign vecReq = s.vecReq;
	assign vecAddr = s.vecAddr;
	assign vecSource = s.lastSel;
	assign stackPush = s.stackPush;
	assign stackPop = s.stackPop;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_global_blocks: assert property ( // R2
		@(posedge mclk) disable iff (rst)
		(cycleStart && s.gd && !s.vecReq) |=> !vecReq)
		else $error("vector issued while globally disabled");

	a_response_side: assert property ( // R3
		@(posedge mclk) disable iff (rst)
		vecReq |-> (globalIrqDisable && stackPush))
		else $error("vector without disable and push");

	a_ext_vector: assert property ( // R5
		@(posedge mclk) disable iff (rst)
		(evalNow && !s.resetPend && reqs[0]) |=> (vecReq && vecAddr == `VEC_EXT))
		else $error("external request did not vector to 08h");

	a_tzero_prio: assert property ( // R23
		@(posedge mclk) disable iff (rst)
		(evalNow && !s.resetPend && !reqs[0] && reqs[1] && reqs[2])
			|=> (vecAddr == `VEC_TZERO))
		else $error("timer zero lost priority to pin edge");

	a_ext_autoclear: assert property ( // R6
		@(posedge mclk) disable iff (rst)
		(sel == SEL_EXT && !extEdge && !wrStat) |=> !s.extF)
		else $error("external flag not cleared on vectoring");

	a_periph_keep: assert property ( // R7
		@(posedge mclk) disable iff (rst)
		(sel == SEL_PERIPH && !wrPf1 && !wrPf2)
			|=> ((($past(s.pf1) & ~s.pf1) & `MASK_SW_FLAG) == 8'h00))
		else $error("peripheral flag cleared by vectoring");

	a_flag_sets: assert property ( // R9
		@(posedge mclk) disable iff (rst)
		timerZeroOvf |=> s.t0F)
		else $error("overflow did not set its flag");

	a_return_pops: assert property ( // R11
		@(posedge mclk) disable iff (rst)
		(retfieExec && !glintdWr) |=> (!globalIrqDisable && stackPop))
		else $error("return did not pop and re-enable");

	a_group_gate: assert property ( // R13
		@(posedge mclk) disable iff (rst)
		(cycleStart && !s.en[`BIT_GROUP_ENABLE])
			|=> !(vecReq && vecAddr == `VEC_PERIPH))
		else $error("peripheral vector with group disabled");

	a_restart_hazard: assert property ( // R14
		@(posedge mclk) disable iff (rst)
		(!s.gd && wrStat && ((s.en[0] && !regWrData[0] && extEdge)
			|| (s.en[1] && !regWrData[1] && timerZeroOvf)))
			|=> s.resetPend || (vecReq && vecAddr == `VEC_RESET))
		else $error("enable clear race did not arm restart");

	a_pin_latency: assert property ( // R24
		@(posedge mclk) disable iff (rst)
		(extEdgeSelect && $rose(extIrqPin)) ##1 (extIrqPin && extEdgeSelect)
			##1 extEdgeSelect |=> s.extF || $past(sel) == SEL_EXT)
		else $error("selected pin edge not flagged in three cycles");

	a_periph_vector: assert property ( // R4
		@(posedge mclk) disable iff (rst)
		(evalNow && !s.resetPend && reqs == 4'h8)
			|=> (vecReq && vecAddr == `VEC_PERIPH && vecSource == SEL_PERIPH))
		else $error("lone peripheral request did not vector to 20h");

	a_restart_vector: assert property ( // R14
		@(posedge mclk) disable iff (rst)
		(evalNow && s.resetPend) |=> (vecReq && vecAddr == `VEC_RESET))
		else $error("armed restart did not vector to 00h");

	a_single_request: assert property ( // R25
		@(posedge mclk) disable iff (rst)
		vecReq |=> !vecReq)
		else $error("vector request stood longer than one cycle");

endmodule

//--- verification/core_seq_model.sv
// Purpose: instruction-cycle sequencer standing in for the processor core
// Assumes: one instruction cycle is four clocks
// Notes: stallAll keeps every cycle a second cycle of a two-cycle instruction
`timescale 1ns/1ps

module core_seq_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control from bench
	input wire logic stallAll,
	// towards the block
	output logic cycleStart,
	output logic instrBusy
);
	logic [1:0] phase;

	// ----------------------------------------
	// cycle pacing
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase <= 2'h0;
			cycleStart <= 1'b0;
			instrBusy <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			cycleStart <= (phase == 2'h3);
			// held busy so no evaluation can slip through a stall
			instrBusy <= stallAll;
		end
	end
endmodule

//--- verification/vectored_interrupt_logic_tb_top.sv
// Purpose: register and vectoring regression for the interrupt logic
// Assumes: read data one cycle after the read strobe
// Notes: software clears peripheral flag register one itself before re-enabling
`timescale 1ns/1ps

module vectored_interrupt_logic_tb_top;
	import vil_pkg::*;
	logic mclk, rst, regWr, regRd, retfieExec, glintdWr, glintdWrData, stallAll;
	logic [7:0] regAddr, regWrData, regRdData, vecAddr, evtOne, evtTwo;
	logic [3:0] regBank;
	logic cycleStart, instrBusy, globalIrqDisable, vecReq, stackPush, stackPop;
	logic extIrqPin, timerClockPin, extEdgeSelect, clkEdgeSelect, timerZeroOvf;
	vec_sel_e vecSource;
	int n_mismatch = 0;
	int n_checks = 0;

	vectored_interrupt_logic u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
		.regBank(regBank), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .cycleStart(cycleStart), .instrBusy(instrBusy),
		.retfieExec(retfieExec), .glintdWr(glintdWr), .glintdWrData(glintdWrData),
		.globalIrqDisable(globalIrqDisable), .vecReq(vecReq), .vecAddr(vecAddr),
		.vecSource(vecSource), .stackPush(stackPush), .stackPop(stackPop),
		.extIrqPin(extIrqPin), .timerClockPin(timerClockPin),
		.extEdgeSelect(extEdgeSelect), .clkEdgeSelect(clkEdgeSelect),
		.timerZeroOvf(timerZeroOvf), .evtOne(evtOne), .evtTwo(evtTwo));

	core_seq_model u_core (.mclk(mclk), .rst(rst), .stallAll(stallAll),
		.cycleStart(cycleStart), .instrBusy(instrBusy));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regBank <= b;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [3:0] b, input logic [7:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regBank <= b;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask

	task automatic gl(input logic v);
		@(posedge mclk);
		glintdWr <= 1'b1;
		glintdWrData <= v;
		@(posedge mclk);
		glintdWr <= 1'b0;
	endtask

	task automatic ret();
		@(posedge mclk);
		retfieExec <= 1'b1;
		@(posedge mclk);
		retfieExec <= 1'b0;
		#1;
		chk({7'h00, stackPop}, 8'h01);
		chk({7'h00, globalIrqDisable}, 8'h00);
	endtask

	// bounded: a lost request must not hang the run
	task automatic waitVec(input logic [7:0] exp, input vec_sel_e src);
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk);
			#1;
			if (vecReq === 1'b1)
				break;
		end
		if (i == 40) begin
			n_mismatch++;
			close_out();
		end
		chk(vecAddr, exp);
		chk({6'h00, stackPush, globalIrqDisable}, 8'h03);
		chk({5'h00, vecSource}, {5'h00, src});
		@(posedge mclk);
		#1;
		chk({7'h00, vecReq}, 8'h00);
	endtask

	task automatic noVec();
		repeat (16) begin
			@(posedge mclk);
			#1;
			chk({7'h00, vecReq}, 8'h00);
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{regWr, regRd, retfieExec, glintdWr, glintdWrData, stallAll} = '0;
		{regAddr, regWrData, regBank} = '0;
		{extIrqPin, timerClockPin, extEdgeSelect, clkEdgeSelect, timerZeroOvf} = '0;
		evtOne = 8'h02;
		evtTwo = 8'h02;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({7'h00, globalIrqDisable}, 8'h01);
		chk({5'h00, vecSource}, {5'h00, SEL_NONE});
		rc(8'h07, 4'h0, 8'h00);
		rc(8'h17, 4'h1, 8'h00);
		rc(8'h11, 4'h4, 8'h00);
		rc(8'h16, 4'h1, 8'h02);
		rc(8'h10, 4'h4, 8'h02);
		rc(8'h33, 4'h2, 8'h00);
		$display("reset values done");
		wr(8'h17, 4'h1, 8'hFF);
		rc(8'h17, 4'h1, 8'hFF);
		wr(8'h11, 4'h4, 8'hFF);
		rc(8'h11, 4'h4, 8'hEF);
		wr(8'h11, 4'h4, 8'h00);
		wr(8'h17, 4'h1, 8'h04);
		$display("enable registers done");
		wr(8'h07, 4'h0, 8'h07);
		clkEdgeSelect <= 1'b1;
		timerClockPin <= 1'b1;
		timerZeroOvf <= 1'b1;
		@(posedge mclk);
		timerZeroOvf <= 1'b0;
		noVec();
		rc(8'h07, 4'h0, 8'h67);
		@(posedge mclk);
		extEdgeSelect <= 1'b1;
		extIrqPin <= 1'b1;
		repeat (4) @(posedge mclk);
		rc(8'h07, 4'h0, 8'h77);
		$display("flags while disabled done");
		gl(1'b0);
		waitVec(8'h08, SEL_EXT);
		rc(8'h07, 4'h0, 8'h67);
		ret();
		waitVec(8'h10, SEL_TZERO);
		rc(8'h07, 4'h0, 8'h47);
		ret();
		waitVec(8'h18, SEL_CLKPIN);
		rc(8'h07, 4'h0, 8'h07);
		@(posedge mclk);
		extEdgeSelect <= 1'b0;
		extIrqPin <= 1'b0;
		clkEdgeSelect <= 1'b0;
		timerClockPin <= 1'b0;
		repeat (4) @(posedge mclk);
		rc(8'h07, 4'h0, 8'h57);
		wr(8'h07, 4'h0, 8'h07);
		$display("fixed vectors done");
		evtOne <= 8'h06;
		evtTwo <= 8'h16;
		@(posedge mclk);
		evtOne <= 8'h02;
		evtTwo <= 8'h02;
		rc(8'h16, 4'h1, 8'h06);
		rc(8'h10, 4'h4, 8'h06);
		rc(8'h07, 4'h0, 8'h87);
		gl(1'b0);
		noVec();
		gl(1'b1);
		wr(8'h07, 4'h0, 8'h0B);
		stallAll <= 1'b1;
		gl(1'b0);
		noVec();
		@(posedge mclk);
		stallAll <= 1'b0;
		waitVec(8'h20, SEL_PERIPH);
		rc(8'h16, 4'h1, 8'h06);
		wr(8'h16, 4'h1, 8'h00);
		rc(8'h16, 4'h1, 8'h02);
		$display("peripheral vector done");
		gl(1'b0);
		@(posedge mclk);
		timerZeroOvf <= 1'b1;
		regAddr <= 8'h07;
		regWrData <= 8'h09;
		regWr <= 1'b1;
		@(posedge mclk);
		timerZeroOvf <= 1'b0;
		regWr <= 1'b0;
		waitVec(8'h00, SEL_RESET);
		$display("restart hazard done");
		close_out();
	end
endmodule
